// [shared/bitrate_pkg.sv]
// Purpose: shared constants and types for the multichannel bit-rate generator
// Assumes: 20 MHz aclk; master timing arrives as a sampled level
// Notes: register map sits on a 32-bit AXI4-Lite slave
package bitrate_pkg;
  localparam int unsigned aclk_hz = 20000000;
  // register byte offsets
  localparam logic [3:0] ctrl_offset = 4'h0;
  localparam logic [3:0] status_offset = 4'h4;
  // control field positions and reset values
  localparam int unsigned ctrl_rate_lsb = 0;
  localparam int unsigned ctrl_aux_bit = 4;
  localparam int unsigned ctrl_ext_sel_bit = 5;
  localparam int unsigned ctrl_ext_in_bit = 6;
  localparam int unsigned ctrl_ext_rate_bit = 7;
  localparam logic [31:0] ctrl_reset = 32'h0000_0020;
  // divider chain counts
  localparam int unsigned div_1800_short = 5;
  localparam int unsigned div_1800_long = 6;
  localparam int unsigned div_110 = 22;
  localparam int unsigned div_134 = 18;
  localparam int unsigned div_200 = 6;
  localparam int unsigned div_50 = 4;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  typedef struct packed {
    logic [2:0] channel_index;
    logic bit_rate;
    logic master_timing;
  } scan_out_type;

  typedef enum logic [2:0] {
    init_idle = 3'b001,
    init_reset = 3'b010,
    init_run = 3'b100
  } init_state_type;
endpackage

// [core/bitrate_gen.sv]
// Purpose: programmable 16x bit-rate generator with 3-bit channel scan
// Assumes: master timing is a sampled level; one rising edge per master cycle
// Notes: registers over AXI4-Lite; ctrl rate and aux bits may also be driven from pins
//
// Functional notes
// RULE1 - top bit low: 0,1 aux input; then 50,75,134.5,200,600,2400 baud
// RULE2 - top bit high: 9600,4800,1800,1200,2400,300,150,110 baud
// RULE3 - every selected output toggles at sixteen times its nominal bit rate
// RULE4 - output flop captures the chosen frequency on each rising master edge
// RULE5 - same edge advances scan counter; output shows previously indexed channel
// RULE6 - clock output high in first half of master cycle; latch reads when low
// RULE7 - outside logic presents channel's rate code before the next master edge
// RULE8 - index bits 0,1 address two four-word files, bit 2 picks the file
// RULE9 - scan refreshes every channel at least once per 9600-baud half cycle
// RULE10 - for 19200 baud, index bit 2 feeds aux input, four channels only
// RULE11 - jumper decoder drives one channel's fixed code; links pull bits low
// RULE12 - single channel five-way switch picks 110..2400 with one bit low
// RULE13 - outside eight-stage shift register holds each channel one scan back
// RULE14 - outside equivalence gate goes low when channel value changed
// RULE15 - outside decoder pulses channel low in clock low half, giving 32x
// RULE16 - select high uses oscillator; low uses external timing; source on clock out
// RULE17 - first high phase of external timing clears all counters
// RULE18 - 1800 baud derived from 9600 dividing alternately by five and six; code divides by 5,6,5 in turn (16/3)
// RULE19 - master timing drives 3-bit scan counter that prescales divider chains
// RULE20 - divider chains run freely regardless of the rate code
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module bitrate_gen
  import bitrate_pkg::*;
(
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic osc_timing_in, // on-chip oscillator level
  input wire logic [31:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [31:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic rate_pins_en, // high: rate code and aux from pins
  input wire logic [3:0] rate_code, // rate code pins
  input wire logic aux_mux_input, // auxiliary multiplexed input pin
  output bitrate_pkg::scan_out_type scan_out // index, bit rate, clock out
);
  import bitrate_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // register file
  logic [31:0] ctrl_ff;
  logic aw_held_ff, w_held_ff;
  logic [31:0] awaddr_ff, wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic do_write;

  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
  assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 32'h0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= ctrl_reset;
      bvalid_ff <= 1'b0;
      bresp_ff <= resp_okay;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      if (awaddr_ff[3:0] == ctrl_offset && awaddr_ff[31:4] == 28'h0) begin
        bresp_ff <= resp_okay;
        if (wstrb_ff[0]) begin
          ctrl_ff[7:0] <= wdata_ff[7:0];
        end
      end else begin
        bresp_ff <= (awaddr_ff[3:0] == status_offset && awaddr_ff[31:4] == 28'h0)
                    ? resp_okay : resp_slverr;
      end
    end else if (bvalid_ff && s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // master timing source and initialization
  logic [3:0] code;
  logic aux_level, ext_sel_n, ext_in, master_lvl, master_d_ff, master_rise;
  init_state_type init_ff;
  logic run, ext_sel_d_ff;

  assign code = rate_pins_en ? rate_code : ctrl_ff[ctrl_rate_lsb +: 4];
  assign aux_level = rate_pins_en ? aux_mux_input : ctrl_ff[ctrl_aux_bit];
  assign ext_sel_n = ctrl_ff[ctrl_ext_sel_bit];
  assign ext_in = ctrl_ff[ctrl_ext_in_bit];
  assign master_lvl = ext_sel_n ? osc_timing_in : ext_in; // [RULE16]
  assign run = (init_ff == init_run);
  assign master_rise = master_lvl && !master_d_ff && run;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      master_d_ff <= 1'b0;
    end else begin
      master_d_ff <= master_lvl;
    end
  end

  // external timing: first high phase holds counters in reset [RULE17]
  // only the switch to external timing arms the reset; later pulses just count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      init_ff <= init_run;
      ext_sel_d_ff <= ctrl_reset[ctrl_ext_sel_bit];
    end else begin
      ext_sel_d_ff <= ext_sel_n;
      case (init_ff)
        init_run: if (!ext_sel_n && ext_sel_d_ff) init_ff <= ext_in ? init_reset : init_idle;
        init_idle: begin
          if (ext_sel_n) init_ff <= init_run;
          else if (ext_in) init_ff <= init_reset;
        end
        init_reset: if (ext_sel_n || !ext_in) init_ff <= init_run;
        default: init_ff <= init_run;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // scan counter and free-running divider chains [RULE19] [RULE20]
  logic [2:0] scan_ff;
  logic [7:0] bin_ff;
  logic [2:0] cnt_1800_ff;
  logic [1:0] phase_1800_ff;
  logic out_1800_ff;
  logic [4:0] cnt_110_ff, cnt_134_ff;
  logic out_110_ff, out_134_ff;
  logic [2:0] cnt_200_ff;
  logic out_200_ff;
  logic [1:0] cnt_50_ff;
  logic out_50_ff;
  logic scan_wrap, bin_tick;
  logic tick_9600, tick_2400, tick_1200, tick_200;
  logic [2:0] lim_1800;

  assign scan_wrap = master_rise && scan_ff == 3'h7;
  assign bin_tick = scan_wrap;
  // a counter bit toggles when all lower bits are one as the chain advances
  assign tick_9600 = bin_tick;
  assign tick_2400 = bin_tick && bin_ff[1:0] == 2'h3;
  assign tick_1200 = bin_tick && bin_ff[2:0] == 3'h7;
  // ticks come every half period of their source, so a full count is one output half
  assign tick_200 = tick_1200 && cnt_200_ff == 3'(div_200 - 1);
  assign lim_1800 = (phase_1800_ff == 2'h1) ? 3'(div_1800_long - 1)
                                            : 3'(div_1800_short - 1);

  always_ff @(posedge aclk) begin
    if (!aresetn || init_ff == init_reset) begin
      scan_ff <= 3'h0;
      bin_ff <= 8'h0;
    end else begin
      if (master_rise) scan_ff <= scan_ff + 3'h1;
      if (bin_tick) bin_ff <= bin_ff + 8'h1;
    end
  end

  // 16/3 on 9600 edges: half periods 5,6,5 -> three outputs per 16 [RULE18]
  always_ff @(posedge aclk) begin
    if (!aresetn || init_ff == init_reset) begin
      cnt_1800_ff <= 3'h0;
      phase_1800_ff <= 2'h0;
      out_1800_ff <= 1'b0;
    end else if (tick_9600) begin
      if (cnt_1800_ff == lim_1800) begin
        cnt_1800_ff <= 3'h0;
        out_1800_ff <= !out_1800_ff;
        phase_1800_ff <= (phase_1800_ff == 2'h2) ? 2'h0 : phase_1800_ff + 2'h1;
      end else begin
        cnt_1800_ff <= cnt_1800_ff + 3'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || init_ff == init_reset) begin
      cnt_110_ff <= 5'h0;
      cnt_134_ff <= 5'h0;
      out_110_ff <= 1'b0;
      out_134_ff <= 1'b0;
    end else if (tick_2400) begin
      cnt_110_ff <= (cnt_110_ff == 5'(div_110 - 1)) ? 5'h0 : cnt_110_ff + 5'h1;
      if (cnt_110_ff == 5'(div_110 - 1)) out_110_ff <= !out_110_ff;
      cnt_134_ff <= (cnt_134_ff == 5'(div_134 - 1)) ? 5'h0 : cnt_134_ff + 5'h1;
      if (cnt_134_ff == 5'(div_134 - 1)) out_134_ff <= !out_134_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || init_ff == init_reset) begin
      cnt_200_ff <= 3'h0;
      out_200_ff <= 1'b0;
      cnt_50_ff <= 2'h0;
      out_50_ff <= 1'b0;
    end else if (tick_1200) begin
      cnt_200_ff <= tick_200 ? 3'h0 : cnt_200_ff + 3'h1;
      if (tick_200) begin
        out_200_ff <= !out_200_ff;
        if (out_200_ff) begin
          cnt_50_ff <= (cnt_50_ff == 2'(div_50 / 2 - 1)) ? 2'h0 : cnt_50_ff + 2'h1;
          if (cnt_50_ff == 2'(div_50 / 2 - 1)) out_50_ff <= !out_50_ff;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rate multiplexer; each source is already 16x its baud [RULE3]
  logic sel_freq;
  always_comb begin
    case (code)
      4'h0, 4'h1: sel_freq = aux_level; // [RULE1] [RULE10]
      4'h2: sel_freq = out_50_ff; // [RULE1]
      4'h3: sel_freq = bin_ff[7];
      4'h4: sel_freq = out_134_ff;
      4'h5: sel_freq = out_200_ff;
      4'h6: sel_freq = bin_ff[4];
      4'h7: sel_freq = bin_ff[2];
      4'h8: sel_freq = bin_ff[0]; // [RULE2]
      4'h9: sel_freq = bin_ff[1];
      4'hA: sel_freq = out_1800_ff;
      4'hB: sel_freq = bin_ff[3];
      4'hC: sel_freq = bin_ff[2];
      4'hD: sel_freq = bin_ff[5];
      4'hE: sel_freq = bin_ff[6];
      4'hF: sel_freq = out_110_ff; // [RULE2]
      default: sel_freq = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // output storage: captured on the edge that also advances scan [RULE4] [RULE5]
  logic bit_rate_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn || init_ff == init_reset) begin
      bit_rate_ff <= 1'b0;
    end else if (master_rise) begin
      bit_rate_ff <= sel_freq; // [RULE7] [RULE9]
    end
  end

  // clock out follows master level: high first half, low second half [RULE6]
  logic clk_out_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_out_ff <= 1'b0;
    end else begin
      clk_out_ff <= master_lvl;
    end
  end

  assign scan_out.channel_index = scan_ff; // [RULE8]
  assign scan_out.bit_rate = bit_rate_ff;
  assign scan_out.master_timing = clk_out_ff;

  // status read shows live scan, output and init state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= resp_okay;
      rdata_ff <= 32'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= resp_okay;
      if (s_axi_araddr[31:4] != 28'h0) begin
        rresp_ff <= resp_slverr;
        rdata_ff <= 32'h0;
      end else if (s_axi_araddr[3:0] == ctrl_offset) begin
        rdata_ff <= {24'h0, ctrl_ff[7:0]};
      end else if (s_axi_araddr[3:0] == status_offset) begin
        rdata_ff <= {24'h0, 1'b0, init_ff, clk_out_ff, bit_rate_ff, scan_ff[1:0]} |
                    {21'h0, scan_ff[2], 10'h0};
      end else begin
        rresp_ff <= resp_slverr;
        rdata_ff <= 32'h0;
      end
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [dv/bitrate_gen_sva.sv]
// Purpose: port-level checks for the bit-rate generator
// Assumes: one aclk domain, synchronous active-low reset
// Notes: bound to bitrate_gen after the module
`timescale 1ns/1ps
`default_nettype none
module bitrate_gen_chk
  import bitrate_pkg::*;
(
  input wire logic aclk, // clock
  input wire logic aresetn, // reset
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic [31:0] s_axi_araddr, // ar address
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // r data
  input wire logic [1:0] s_axi_rresp, // r response
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire bitrate_pkg::scan_out_type scan_out // scan outputs
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire logic [2:0] idx = scan_out.channel_index;
  wire logic mt = scan_out.master_timing;
  wire logic br = scan_out.bit_rate;
  ////////////////////////////////////////////////////////////////////////////////
  // zero is exempt: the external init reset clears the index with no rise
  a_scan_step: assert property (
    $changed(idx) |-> idx == $past(idx) + 3'h1 || idx == 3'h0)
    else $error("scan index did not step by one");
  a_scan_cause: assert property (
    $changed(idx) && idx != 3'h0 |-> mt)
    else $error("scan index moved outside a master high phase");
  a_scan_follow: assert property (
    $rose(mt) |-> ##[0:2] ($changed(idx) || idx == 3'h0))
    else $error("master rise did not advance the scan");
  a_rate_cause: assert property (
    $changed(br) |-> $changed(idx) || idx == 3'h0)
    else $error("bit rate moved without a master edge");
  // a register write that switches the timing source may cut a high phase short
  a_timing_width: assert property ($rose(mt) && !s_axi_bvalid |=> mt)
    else $error("clock out high for a single cycle");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_read_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 32'h4
    |=> s_axi_rresp == resp_slverr && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  c_wrap: cover property (idx == 3'h7 ##[1:8] idx == 3'h0);
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == resp_slverr);
  c_rate_edge: cover property ($changed(br));
endmodule
bind bitrate_gen bitrate_gen_chk u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .scan_out(scan_out)
);
`default_nettype wire

// [dv/bitrate_partner.sv]
// Purpose: far side: channel code files, aux wiring and demux latch
// Assumes: scan outputs as driven by bitrate_gen
// Notes: files hold aux codes only, so the four-channel aux wiring shows
`timescale 1ns/1ps
`default_nettype none
module bitrate_partner
  import bitrate_pkg::*;
(
  input wire logic aclk, // clock
  input wire bitrate_pkg::scan_out_type scan_out, // generator outputs
  input wire logic use_files, // codes from files
  input wire logic [3:0] fixed_code, // switch or jumper code
  output logic [3:0] rate_code, // code for indexed channel
  output logic aux_mux_input, // aux level
  output logic [7:0] chan_out, // demultiplexed outputs
  output logic [7:0] chan_x32 // 32x lines, low pulse when a channel moved
);
  localparam logic [3:0] file_lo [4] = '{4'h0, 4'h1, 4'h0, 4'h1};
  localparam logic [3:0] file_hi [4] = '{4'h1, 4'h0, 4'h1, 4'h0};
  logic [3:0] file_word;
  // bit 2 enables one file, bits 1:0 address it
  assign file_word = scan_out.channel_index[2] ? file_hi[scan_out.channel_index[1:0]]
    : file_lo[scan_out.channel_index[1:0]];
  assign rate_code = use_files ? file_word : fixed_code;
  assign aux_mux_input = scan_out.channel_index[2];
  // only while clock out is low, when index and bit rate are settled
  always_ff @(posedge aclk) begin
    if (!scan_out.master_timing) begin
      chan_out[scan_out.channel_index] <= scan_out.bit_rate;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // 32x scheme: shift on the rise of clock out, taking the value from before it
  logic [7:0] stage_ff;
  logic br_d_ff, mt_d_ff, chan_moved;
  always_ff @(posedge aclk) begin
    br_d_ff <= scan_out.bit_rate;
    mt_d_ff <= scan_out.master_timing;
    if (scan_out.master_timing && !mt_d_ff) begin
      stage_ff <= {stage_ff[6:0], br_d_ff};
    end
  end
  assign chan_moved = stage_ff[7] != scan_out.bit_rate;
  for (genvar i = 0; i < 8; i++) begin : g_x32
    assign chan_x32[i] = !(chan_moved && !scan_out.master_timing &&
      scan_out.channel_index == 3'(i));
  end
endmodule
`default_nettype wire

// [dv/multichannel_bit_rate_generator_tb_top.sv]
// Purpose: self-checking bench for bitrate_gen
// Assumes: oscillator level flips every 2 aclk, one master cycle is 4 aclk
// Notes: rates are checked as scan steps per half period of bit_rate
`timescale 1ns/1ps
`default_nettype none
module multichannel_bit_rate_generator_tb_top;
  import bitrate_pkg::*;
  logic aclk, aresetn = 1'b0, osc_timing_in = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, rate_pins_en = 1'b1, use_files = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, aux;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] fixed_code = 4'h0, rate_code;
  logic [7:0] chan_out, chan_x32;
  int x32_falls = 0;
  scan_out_type scan_out;
  int fails = 0, cmp_count = 0;
  localparam int half_steps [16] = '{0, 0, 1536, 1024, 576, 384, 128, 32,
    8, 16, 40, 64, 32, 256, 512, 704};
  bitrate_gen u_dut (.aclk(aclk), .aresetn(aresetn), .osc_timing_in(osc_timing_in),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rate_pins_en(rate_pins_en),
    .rate_code(rate_code), .aux_mux_input(aux), .scan_out(scan_out));
  bitrate_partner u_partner (.aclk(aclk), .scan_out(scan_out), .use_files(use_files),
    .fixed_code(fixed_code), .rate_code(rate_code), .aux_mux_input(aux), .chan_out(chan_out),
    .chan_x32(chan_x32));
  always @(negedge chan_x32[0]) x32_falls++;
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  initial begin
    forever begin
      repeat (2) @(posedge aclk);
      osc_timing_in <= ~osc_timing_in;
    end
  end
  initial begin
    repeat (90000) @(posedge aclk);
    fails++;
    give_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_range(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // rready is raised late on purpose so the slave must hold its answer
  task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic steps(input int n);
    logic [2:0] i;
    repeat (n) begin
      i = scan_out.channel_index;
      while (scan_out.channel_index === i) @(negedge aclk);
    end
  endtask
  task automatic count_half(output int n);
    logic b;
    b = scan_out.bit_rate;
    n = 0;
    while (scan_out.bit_rate === b) begin
      steps(1);
      n++;
    end
  endtask
  // the first two halves after a code change may be partial
  task automatic measure(input logic [3:0] c, input int lo, input int hi);
    int n;
    @(posedge aclk);
    fixed_code <= c;
    repeat (3) count_half(n);
    check_range(n, lo, hi);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [2:0] prev;
    int n;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read({28'h0, ctrl_offset}, d, r);
    check_val(d, ctrl_reset);
    axi_write({28'h0, ctrl_offset}, 32'hFFFF_FF28, r);
    axi_read({28'h0, ctrl_offset}, d, r);
    check_val(d, 32'h0000_0028);
    axi_read(32'h0000_0008, d, r);
    check_val({d[31:2], r}, {30'h0, resp_slverr});
    axi_write(32'h0000_0008, 32'h0000_0000, r);
    check_val({30'h0, r}, {30'h0, resp_slverr});
    @(posedge aclk);
    rate_pins_en <= 1'b0;
    measure(4'h0, 8, 8);
    // all channels at 9600 move once per scan round, so one 32x pulse per 8 steps
    n = x32_falls;
    steps(64);
    check_range(x32_falls - n, 7, 9);
    @(posedge aclk);
    rate_pins_en <= 1'b1;
    $display("test registers done");
    for (int c = 2; c < 16; c++) begin
      measure(4'(c), half_steps[c], (c == 10) ? 48 : half_steps[c]);
    end
    $display("test rate codes done");
    @(posedge aclk);
    use_files <= 1'b1;
    steps(10);
    for (int k = 0; k < 8; k++) begin
      steps(1);
      prev = scan_out.channel_index - 3'h1;
      check_val({31'h0, scan_out.bit_rate}, {31'h0, prev[2]});
    end
    check_val({24'h0, chan_out}, 32'h0000_00E1);
    $display("test scan done");
    @(posedge aclk);
    use_files <= 1'b0;
    axi_write({28'h0, ctrl_offset}, 32'h0000_0000, r);
    axi_write({28'h0, ctrl_offset}, 32'h0000_0040, r);
    axi_read({28'h0, status_offset}, d, r);
    check_val({d[6:4], 26'h0, scan_out.channel_index}, {3'h2, 29'h0});
    axi_write({28'h0, ctrl_offset}, 32'h0000_0000, r);
    axi_write({28'h0, ctrl_offset}, 32'h0000_0040, r);
    axi_read({28'h0, status_offset}, d, r);
    check_val({d[6:4], 26'h0, scan_out.channel_index}, {3'h4, 29'h1});
    $display("test external timing done");
    give_verdict();
  end
endmodule
`default_nettype wire
